// >>> include/spe_pkg.sv
// shared constants and types for the serial nonvolatile command port
package spe_pkg;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam int STAT_PROTECT_PIN_EN_BIT = 7;
   localparam int STAT_GUARD_HI_BIT = 3;
   localparam int STAT_GUARD_LO_BIT = 2;
   localparam int STAT_LATCH_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam logic [2:0] STAT_UNDEF_VALUE = 3'h0;
   localparam logic STAT_PROTECT_PIN_EN_RESET = 1'b0;
   localparam logic [1:0] STAT_GUARD_RESET = 2'h0;
   localparam int ADDR_BITS = 16;
   localparam int CLK_HZ = 25_000_000;
   localparam int WRITE_CYCLE_US = 6000;
   localparam int WRITE_CYCLE_CYC = (CLK_HZ / 1_000_000) * WRITE_CYCLE_US;
   typedef enum logic [2:0] {
      PH_OPCODE, PH_ADDR, PH_READ_DATA, PH_WRITE_DATA, PH_STATUS_OUT, PH_STATUS_IN, PH_IGNORE
   } spe_phase_t;
endpackage

// >>> include/spe_mem_if.sv
// port between the command engine and the byte array
`timescale 1ns/1ps
interface spe_mem_if #(parameter int AW = 15);
   logic [AW-1:0] rd_addr;
   logic [7:0] rd_data;
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [7:0] wr_data;
   modport eng (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
   modport mem (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface

// >>> hw/spe_array.sv
// flip-flop byte array
`timescale 1ns/1ps
module spe_array #(
   parameter int AW = 15
) (
   input wire logic clk,
   spe_mem_if.mem mem
);
   logic [7:0] store_q [2**AW];
   logic [7:0] store_d [2**AW];

   always_comb begin
      store_d = store_q;
      if (mem.wr_en) begin
         store_d[mem.wr_addr] = mem.wr_data;
      end
   end

   // contents are nonvolatile in spirit, so no reset is applied
   always_ff @(posedge clk) begin
      store_q <= store_d;
   end

   assign mem.rd_data = store_q[mem.rd_addr];
endmodule

// >>> hw/spe_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module spe_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic s1_q, s2_q, s3_q, out_q;
   logic out_d;

   always_comb begin
      out_d = out_q;
      if (s2_q == s3_q) begin
         out_d = s3_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         out_q <= INIT;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign dout = out_q;
endmodule

// >>> hw/spe_top.sv
// serial nonvolatile memory command port
`timescale 1ns/1ps
module spe_top #(
   parameter int AW = 15,
   parameter int PAGE = 64,
   parameter int WRITE_CYC = spe_pkg::WRITE_CYCLE_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   input wire logic PAUSE_N,
   input wire logic PROTECT_N,
   output logic SO,
   output logic SO_OE
);
   localparam int PW = $clog2(PAGE);

   initial begin
      // the flush walks the whole page buffer, so the write cycle must outlast it
      if (AW < 8 || AW > spe_pkg::ADDR_BITS || PAGE < 2 || (1 << PW) != PAGE || PW >= AW
          || WRITE_CYC <= PAGE) begin
         $error("spe_top: unsupported array or page size");
      end
   end

   logic rst_a_q, rst_q;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_a_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_q <= rst_a_q;
      end
   end

   logic cs_n, sck, si, pause_n, prot_n;
   spe_sync #(.INIT(1'b1)) u_cs (.clk(REF_CLK), .rst_n(rst_q), .din(CS_N), .dout(cs_n));
   spe_sync #(.INIT(1'b0)) u_sck (.clk(REF_CLK), .rst_n(rst_q), .din(SCK), .dout(sck));
   spe_sync #(.INIT(1'b0)) u_si (.clk(REF_CLK), .rst_n(rst_q), .din(SI), .dout(si));
   spe_sync #(.INIT(1'b1)) u_pause (.clk(REF_CLK), .rst_n(rst_q), .din(PAUSE_N), .dout(pause_n));
   spe_sync #(.INIT(1'b1)) u_prot (.clk(REF_CLK), .rst_n(rst_q), .din(PROTECT_N), .dout(prot_n));

   spe_mem_if #(.AW(AW)) mif ();
   spe_array #(.AW(AW)) u_array (.clk(REF_CLK), .mem(mif));

   function automatic logic guarded(input logic [1:0] g, input logic [AW-1:0] a);
      unique case (g)
         2'b00: guarded = 1'b0;
         2'b01: guarded = (a[AW-1:AW-2] == 2'b11);
         2'b10: guarded = a[AW-1];
         2'b11: guarded = 1'b1;
      endcase
   endfunction

   spe_pkg::spe_phase_t ph_q, ph_d;
   logic sck_q, cs_n_q, paused_q, paused_d;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, out_q, out_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [7:0] op_q, op_d;
   logic latch_q, latch_d, pen_q, pen_d;
   logic [1:0] guard_q, guard_d;
   logic [7:0] page_q [PAGE];
   logic [7:0] page_d [PAGE];
   logic [PAGE-1:0] pvalid_q, pvalid_d;
   logic armed_q, armed_d, sw_armed_q, sw_armed_d;
   logic [7:0] sw_val_q, sw_val_d;
   logic busy_q, busy_d;
   logic [31:0] tmr_q, tmr_d;
   logic [PW:0] flush_q, flush_d;
   logic so_q, so_d, oe_q, oe_d;
   logic active_q, active_d;
   logic [AW-1:0] base_q, base_d;

   logic rise, fall, cs_fall, cs_rise;
   assign rise = sck && !sck_q && !cs_n && !paused_q;
   assign fall = !sck && sck_q;
   assign cs_fall = !cs_n && cs_n_q;
   assign cs_rise = cs_n && !cs_n_q;

   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[spe_pkg::STAT_PROTECT_PIN_EN_BIT] = pen_q;
      status[6:4] = spe_pkg::STAT_UNDEF_VALUE;
      status[spe_pkg::STAT_GUARD_HI_BIT] = guard_q[1];
      status[spe_pkg::STAT_GUARD_LO_BIT] = guard_q[0];
      status[spe_pkg::STAT_LATCH_BIT] = latch_q;
      status[spe_pkg::STAT_BUSY_BIT] = busy_q;
   end

   assign mif.rd_addr = addr_q;

   always_comb begin
      ph_d = ph_q;
      paused_d = paused_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      out_d = out_q;
      addr_d = addr_q;
      op_d = op_q;
      latch_d = latch_q;
      pen_d = pen_q;
      guard_d = guard_q;
      page_d = page_q;
      pvalid_d = pvalid_q;
      armed_d = armed_q;
      sw_armed_d = sw_armed_q;
      sw_val_d = sw_val_q;
      busy_d = busy_q;
      tmr_d = tmr_q;
      flush_d = flush_q;
      so_d = so_q;
      oe_d = oe_q;
      active_d = active_q;
      base_d = base_q;
      mif.wr_en = 1'b0;
      mif.wr_addr = base_q | AW'(flush_q[PW-1:0]);
      mif.wr_data = page_q[flush_q[PW-1:0]];
      // pause: a fall of the pause pin with the serial clock low acts at once, else on next fall
      if (!cs_n && !pause_n && !paused_q && (!sck || fall)) begin
         paused_d = 1'b1;
      end
      if (paused_q && pause_n && (!sck || fall)) begin
         paused_d = 1'b0;
      end
      if (cs_fall) begin
         ph_d = spe_pkg::PH_OPCODE;
         cnt_d = 5'd0;
         active_d = 1'b1;
         armed_d = 1'b0;
         sw_armed_d = 1'b0;
         // a flush still running owns the page buffer
         if (!busy_q) begin
            pvalid_d = '0;
         end
         paused_d = 1'b0;
      end else if (rise && active_q) begin
         sh_d = {sh_q[6:0], si};
         cnt_d = cnt_q + 5'd1;
         unique case (ph_q)
            spe_pkg::PH_OPCODE: begin
               if (cnt_q == 5'd7) begin
                  op_d = sh_d;
                  cnt_d = 5'd0;
                  unique case (sh_d)
                     spe_pkg::OP_READ, spe_pkg::OP_WRITE: ph_d = spe_pkg::PH_ADDR;
                     spe_pkg::OP_STATUS_READ: begin
                        ph_d = spe_pkg::PH_STATUS_OUT;
                        out_d = status;
                     end
                     spe_pkg::OP_STATUS_WRITE: ph_d = spe_pkg::PH_STATUS_IN;
                     spe_pkg::OP_SET_LATCH, spe_pkg::OP_CLEAR_LATCH: begin
                        ph_d = spe_pkg::PH_IGNORE;
                        armed_d = !busy_q;
                     end
                     default: ph_d = spe_pkg::PH_IGNORE;
                  endcase
               end
            end
            spe_pkg::PH_ADDR: begin
               addr_d = {addr_q[AW-2:0], si};
               if (cnt_q == 5'd15) begin
                  cnt_d = 5'd0;
                  base_d = {addr_d[AW-1:PW], PW'(0)};
                  if (op_q == spe_pkg::OP_READ) begin
                     // array reads are refused during the write cycle
                     ph_d = busy_q ? spe_pkg::PH_IGNORE : spe_pkg::PH_READ_DATA;
                     out_d = mif.rd_data;
                  end else begin
                     ph_d = spe_pkg::PH_WRITE_DATA;
                  end
               end
            end
            spe_pkg::PH_READ_DATA: begin
               if (cnt_q == 5'd7) begin
                  cnt_d = 5'd0;
                  addr_d = addr_q + AW'(1);
               end
            end
            spe_pkg::PH_STATUS_OUT: begin
               if (cnt_q == 5'd7) begin
                  cnt_d = 5'd0;
               end
            end
            spe_pkg::PH_WRITE_DATA: begin
               armed_d = 1'b0;
               if (cnt_q == 5'd7) begin
                  cnt_d = 5'd0;
                  if (!busy_q) begin
                     page_d[addr_q[PW-1:0]] = sh_d;
                     pvalid_d[addr_q[PW-1:0]] = 1'b1;
                  end
                  addr_d = {addr_q[AW-1:PW], addr_q[PW-1:0] + PW'(1)};
                  armed_d = 1'b1;
               end
            end
            spe_pkg::PH_STATUS_IN: begin
               sw_armed_d = 1'b0;
               if (cnt_q == 5'd7) begin
                  sw_val_d = sh_d;
                  sw_armed_d = 1'b1;
                  ph_d = spe_pkg::PH_IGNORE;
               end
            end
            spe_pkg::PH_IGNORE: begin
               armed_d = 1'b0;
               sw_armed_d = 1'b0;
               cnt_d = cnt_q;
            end
         endcase
      end
      if (fall && active_q && !paused_q && !cs_n) begin
         if (ph_q == spe_pkg::PH_READ_DATA || ph_q == spe_pkg::PH_STATUS_OUT) begin
            oe_d = 1'b1;
            so_d = out_q[7];
            out_d = {out_q[6:0], 1'b0};
            if (cnt_q == 5'd0) begin
               so_d = (ph_q == spe_pkg::PH_READ_DATA) ? mif.rd_data[7] : status[7];
               out_d = (ph_q == spe_pkg::PH_READ_DATA) ? {mif.rd_data[6:0], 1'b0} : {status[6:0], 1'b0};
            end
         end
      end
      if (cs_rise) begin
         active_d = 1'b0;
         oe_d = 1'b0;
         if (armed_q && ph_q == spe_pkg::PH_IGNORE && op_q == spe_pkg::OP_SET_LATCH) begin
            latch_d = 1'b1;
         end
         if (armed_q && ph_q == spe_pkg::PH_IGNORE && op_q == spe_pkg::OP_CLEAR_LATCH) begin
            latch_d = 1'b0;
         end
         if (armed_q && ph_q == spe_pkg::PH_WRITE_DATA && latch_q && !busy_q
             && !guarded(guard_q, base_q)) begin
            busy_d = 1'b1;
            tmr_d = 32'(WRITE_CYC);
            flush_d = '0;
         end
         if (sw_armed_q && latch_q && !busy_q && !(pen_q && !prot_n)) begin
            busy_d = 1'b1;
            tmr_d = 32'(WRITE_CYC);
            flush_d = (PW+1)'(PAGE);
            pen_d = sw_val_d[spe_pkg::STAT_PROTECT_PIN_EN_BIT];
            guard_d = {sw_val_d[spe_pkg::STAT_GUARD_HI_BIT], sw_val_d[spe_pkg::STAT_GUARD_LO_BIT]};
         end
      end
      if (busy_q) begin
         if (flush_q != (PW+1)'(PAGE)) begin
            mif.wr_en = pvalid_q[flush_q[PW-1:0]];
            flush_d = flush_q + (PW+1)'(1);
         end
         tmr_d = tmr_q - 32'd1;
         if (tmr_q == 32'd1) begin
            busy_d = 1'b0;
            latch_d = 1'b0;
            pvalid_d = '0;
         end
      end
      // pause floats the output whatever the serial clock does
      if (!pause_n) begin
         oe_d = 1'b0;
      end else if (active_q && !cs_n && (ph_q == spe_pkg::PH_READ_DATA || ph_q == spe_pkg::PH_STATUS_OUT)
                   && (cnt_q != 5'd0 || oe_q || paused_q)) begin
         oe_d = oe_q | paused_q;
      end
      if (cs_n) begin
         oe_d = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_q) begin
      if (!rst_q) begin
         ph_q <= spe_pkg::PH_IGNORE;
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
         paused_q <= 1'b0;
         cnt_q <= 5'd0;
         sh_q <= 8'h00;
         out_q <= 8'h00;
         addr_q <= '0;
         op_q <= 8'h00;
         latch_q <= 1'b0;
         pen_q <= spe_pkg::STAT_PROTECT_PIN_EN_RESET;
         guard_q <= spe_pkg::STAT_GUARD_RESET;
         pvalid_q <= '0;
         armed_q <= 1'b0;
         sw_armed_q <= 1'b0;
         sw_val_q <= 8'h00;
         busy_q <= 1'b0;
         tmr_q <= 32'd0;
         flush_q <= '0;
         so_q <= 1'b0;
         oe_q <= 1'b0;
         active_q <= 1'b0;
         base_q <= '0;
      end else begin
         ph_q <= ph_d;
         sck_q <= sck;
         cs_n_q <= cs_n;
         paused_q <= paused_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         out_q <= out_d;
         addr_q <= addr_d;
         op_q <= op_d;
         latch_q <= latch_d;
         pen_q <= pen_d;
         guard_q <= guard_d;
         pvalid_q <= pvalid_d;
         armed_q <= armed_d;
         sw_armed_q <= sw_armed_d;
         sw_val_q <= sw_val_d;
         busy_q <= busy_d;
         tmr_q <= tmr_d;
         flush_q <= flush_d;
         so_q <= so_d;
         oe_q <= oe_d;
         active_q <= active_d;
         base_q <= base_d;
      end
   end

   always_ff @(posedge REF_CLK) begin
      page_q <= page_d;
   end

   assign SO = so_q;
   assign SO_OE = oe_q;

   AST_PAUSE_FLOATS: assert property (@(posedge REF_CLK) disable iff (!rst_q)
      !pause_n |=> !SO_OE) else $error("output driven while paused");
   AST_DESELECT_FLOATS: assert property (@(posedge REF_CLK) disable iff (!rst_q)
      cs_n |=> !SO_OE) else $error("output driven while deselected");
   AST_BUSY_CLEARS_LATCH: assert property (@(posedge REF_CLK) disable iff (!rst_q)
      $fell(busy_q) |-> !latch_q) else $error("latch still set after write cycle");
   AST_BUSY_NEEDS_LATCH: assert property (@(posedge REF_CLK) disable iff (!rst_q)
      $rose(busy_q) |-> $past(latch_q)) else $error("write cycle without latch");
   AST_NO_READ_WHILE_BUSY: assert property (@(posedge REF_CLK) disable iff (!rst_q)
      busy_q && ph_q == spe_pkg::PH_ADDR && ph_d != spe_pkg::PH_ADDR && op_q == spe_pkg::OP_READ
      |=> ph_q == spe_pkg::PH_IGNORE) else $error("array read served while busy");
   AST_PAUSE_FREEZES: assert property (@(posedge REF_CLK) disable iff (!rst_q)
      paused_q && !cs_fall |=> $stable(cnt_q) && $stable(sh_q)) else $error("bit position moved while paused");
   AST_GUARD_ONLY_STATUS_WRITE: assert property (@(posedge REF_CLK) disable iff (!rst_q)
      !$stable(guard_q) |-> $past(sw_armed_q) && $past(cs_rise)) else $error("guard changed");
   AST_BUSY_BOUNDED: assert property (@(posedge REF_CLK) disable iff (!rst_q)
      busy_q |-> tmr_q <= 32'(WRITE_CYC)) else $error("write cycle overran");
endmodule

// >>> sim/spe_host.sv
// host-side serial master model driving the command port pins
`timescale 1ns/1ps
module spe_host (
   input wire logic clk,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic pause_n,
   input wire logic so,
   input wire logic so_oe
);
   logic oe_seen;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      pause_n = 1'b1;
      oe_seen = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // four ref clocks a phase; output read late in the high phase, as it lags the fall
   task automatic bitx(input logic b, output logic r);
      si = b;
      tick(4);
      sck = 1'b1;
      tick(3);
      // a floating output must not pass for data
      r = so_oe ? so : ~so;
      oe_seen = oe_seen | so_oe;
      tick(1);
      sck = 1'b0;
   endtask
   task automatic xbyte(input logic [7:0] t, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) bitx(t[i], r[i]);
   endtask
   task automatic start();
      oe_seen = 1'b0;
      cs_n = 1'b0;
      tick(4);
   endtask
   task automatic stop();
      tick(4);
      cs_n = 1'b1;
      si = ~si; // a released line keeps no stale value
      tick(6);
   endtask
   task automatic hold(input logic l);
      pause_n = l;
      tick(6);
   endtask
   task automatic noise();
      repeat (3) begin
         si = ~si;
         sck = 1'b1;
         tick(4);
         sck = 1'b0;
         tick(4);
      end
   endtask
endmodule

// >>> sim/spi_eeprom_command_port_tb.sv
// self-checking bench for the serial command port
`timescale 1ns/1ps
module spi_eeprom_command_port_tb;
   localparam int PG = 16;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic protect_n = 1'b1;
   logic cs_n;
   logic sck;
   logic si;
   logic pause_n;
   logic so;
   logic so_oe;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   always #20 ref_clk = ~ref_clk;
   // short write cycle and a 16-byte page keep the run brief
   // long enough that a status poll and a full read header still fall inside it
   spe_top #(.AW(15), .PAGE(PG), .WRITE_CYC(600)) uut (.REF_CLK(ref_clk), .RST_N(rst_n), .CS_N(cs_n),
      .SCK(sck), .SI(si), .PAUSE_N(pause_n), .PROTECT_N(protect_n), .SO(so), .SO_OE(so_oe));
   spe_host host (.clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n), .so(so), .so_oe(so_oe));
   task automatic test_done();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         errors++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd_addr(input logic [7:0] c, input logic [15:0] a);
      logic [7:0] r;
      host.start();
      host.xbyte(c, r);
      host.xbyte(a[15:8], r);
      host.xbyte(a[7:0], r);
   endtask
   task automatic op(input logic [7:0] c, input logic [7:0] v, input int n);
      logic [7:0] r;
      host.start();
      host.xbyte(c, r);
      if (n > 1) host.xbyte(v, r);
      host.stop();
   endtask
   task automatic st_chk(input logic [7:0] e);
      logic [7:0] s;
      host.start();
      host.xbyte(spe_pkg::OP_STATUS_READ, s);
      host.xbyte(8'h00, s);
      host.stop();
      chk(s, e);
   endtask
   task automatic idle(input logic [7:0] e);
      logic [7:0] s;
      s = 8'h01;
      for (int i = 0; i < 8 && s[0] !== 1'b0; i++) begin
         host.start();
         host.xbyte(spe_pkg::OP_STATUS_READ, s);
         host.xbyte(8'h00, s);
         host.stop();
      end
      chk(s, e);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
      logic [7:0] r;
      cmd_addr(spe_pkg::OP_WRITE, a);
      foreach (d[i]) host.xbyte(d[i], r);
      host.stop();
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e[$]);
      logic [7:0] r;
      cmd_addr(spe_pkg::OP_READ, a);
      foreach (e[i]) begin
         host.xbyte(8'h00, r);
         chk(r, e[i]);
      end
      host.stop();
   endtask
   task automatic t_latch();
      logic [7:0] r;
      chk({7'h00, so_oe}, 8'h00);
      st_chk(8'h00);
      op(spe_pkg::OP_SET_LATCH, 8'h00, 1);
      st_chk(8'h02);
      op(spe_pkg::OP_CLEAR_LATCH, 8'h00, 1);
      st_chk(8'h00);
      host.start();
      host.xbyte(spe_pkg::OP_SET_LATCH, r);
      host.xbyte(spe_pkg::OP_WRITE, r);
      host.stop();
      st_chk(8'h00);
      wr(16'h0000, '{8'h11});
      st_chk(8'h00);
   endtask
   task automatic t_page();
      logic [7:0] r;
      op(spe_pkg::OP_SET_LATCH, 8'h00, 1);
      wr(16'(PG - 2), '{8'ha1, 8'hb2, 8'hc3});
      st_chk(8'h03);
      cmd_addr(spe_pkg::OP_READ, 16'h0000);
      host.xbyte(8'h00, r);
      host.stop();
      chk({7'h00, host.oe_seen}, 8'h00);
      idle(8'h00);
      op(spe_pkg::OP_SET_LATCH, 8'h00, 1);
      wr(16'h7fff, '{8'hd4});
      idle(8'h00);
      rd_chk(16'h7fff, '{8'hd4, 8'hc3});
      rd_chk(16'(PG - 2), '{8'ha1, 8'hb2});
   endtask
   task automatic t_partial();
      logic r;
      op(spe_pkg::OP_SET_LATCH, 8'h00, 1);
      cmd_addr(spe_pkg::OP_WRITE, 16'h0000);
      repeat (4) host.bitx(1'b1, r);
      host.stop();
      st_chk(8'h02);
      rd_chk(16'h0000, '{8'hc3});
      op(spe_pkg::OP_CLEAR_LATCH, 8'h00, 1);
   endtask
   task automatic t_guard();
      op(spe_pkg::OP_SET_LATCH, 8'h00, 1);
      op(spe_pkg::OP_STATUS_WRITE, 8'h84, 2);
      idle(8'h84);
      protect_n = 1'b0;
      op(spe_pkg::OP_SET_LATCH, 8'h00, 1);
      op(spe_pkg::OP_STATUS_WRITE, 8'h00, 2);
      st_chk(8'h86);
      wr(16'h6000, '{8'h5a});
      st_chk(8'h86);
      wr(16'h0010, '{8'h5b});
      st_chk(8'h87);
      idle(8'h84);
      rd_chk(16'h0010, '{8'h5b});
      protect_n = 1'b1;
      op(spe_pkg::OP_SET_LATCH, 8'h00, 1);
      op(spe_pkg::OP_STATUS_WRITE, 8'h00, 2);
      idle(8'h00);
   endtask
   task automatic t_unknown();
      logic [7:0] r;
      host.start();
      host.xbyte(8'hff, r);
      host.xbyte(spe_pkg::OP_STATUS_READ, r);
      host.xbyte(8'h00, r);
      host.stop();
      chk({7'h00, host.oe_seen}, 8'h00);
   endtask
   task automatic t_pause();
      logic [7:0] r;
      cmd_addr(spe_pkg::OP_READ, 16'(PG - 2));
      for (int i = 7; i >= 4; i--) host.bitx(1'b0, r[i]);
      host.hold(1'b0);
      chk({7'h00, so_oe}, 8'h00);
      host.noise();
      host.hold(1'b1);
      chk({7'h00, so_oe}, 8'h01);
      for (int i = 3; i >= 0; i--) host.bitx(1'b0, r[i]);
      chk(r, 8'ha1);
      host.xbyte(8'h00, r);
      chk(r, 8'hb2);
      host.stop();
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      t_latch();
      t_page();
      t_partial();
      t_guard();
      t_unknown();
      t_pause();
      test_done();
   end
endmodule
